// ### bench/bcs_channel_bench.sv
// Self-checking bench of one buck channel supervisor.
`timescale 1ns/1ps
module bcs_channel_bench
    import bcs_pkg::*;
;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    // Short hiccup so the run stays brief.
    localparam logic [12:0] HIC = 13'h0010;
    logic clk_sys = 1'b0;
    logic tick = 1'b0;
    logic nrst, ce, overload, trip, pg_o, pg_oe, hic;
    bcs_sense_type sn, sense_in;
    bcs_gate_type gate;
    bcs_state_type state;
    logic [6:0] ref_level;
    logic [2:0] occ;
    int bad_count, checks_done;
    // Comparator outputs, with the source trip taken from the stage model.
    always_comb
    begin
        sense_in = sn;
        sense_in.src_trip = trip;
    end
    bcs_channel #(.HICCUP_CYCLES(HIC)) DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .tick(tick), .sense(sense_in), .gate(gate), .power_ok_output_o(pg_o),
        .power_ok_output_oe(pg_oe), .state(state), .hiccup_active(hic),
        .ref_level(ref_level), .occ_count(occ));
    bcs_power_stage PS (.gate(gate), .overload(overload), .src_trip(trip));
    // Clock, and a switching cycle of two clocks.
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys)
        tick <= nrst ? ~tick : 1'b0;
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_v(input logic [6:0] got, input logic [6:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_st(input bcs_state_type got, input bcs_state_type exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: state %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic steps(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Bounded wait for a state; running out ends the run.
    task automatic wait_st(input bcs_state_type e, input int lim);
        int n;
        n = 0;
        while (state !== e && n < lim)
        begin
            @(negedge clk_sys);
            n++;
        end
        cmp_st(state, e);
        if (state !== e)
            results();
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        steps(10);
        cmp_v(gate, 7'h00);
        cmp_v(pg_oe, 7'h01);
        cmp_v(pg_o, 7'h00);
        cmp_st(state, BCS_OFF);
        cmp_v(occ, 7'h00);
        nrst = 1'b1;
    endtask
    // Lockout, enable, prebias hold and first pulse.
    task automatic t_startup();
        sn.supply_low_lockout = 1'b1;
        sn.en_ok = 1'b1;
        sn.hs_demand = 1'b1;
        steps(40);
        cmp_v(gate, 7'h00);
        cmp_st(state, BCS_OFF);
        sn.supply_low_lockout = 1'b0;
        wait_st(BCS_WAIT_FIRST, 10);
        steps(90);
        cmp_v(gate, 7'h00);
        cmp_v(ref_level, 7'h01);
        sn.ref_above_fb = 1'b1;
        wait_st(BCS_SOFT_START, 4);
        steps(1);
        cmp_v(gate, 7'h02);
        sn.hs_demand = 1'b0;
        wait_st(BCS_RUN, 5000);
        cmp_v(ref_level, 7'h40);
        cmp_v(gate, 7'h01);
    endtask
    // Power good hysteresis and sink limit in regulation.
    task automatic t_run_checks();
        sn.fb_above_upper = 1'b1;
        steps(2);
        cmp_v(pg_oe, 7'h00);
        sn.fb_above_upper = 1'b0;
        sn.fb_below_lower = 1'b1;
        steps(2);
        cmp_v(pg_oe, 7'h01);
        sn.fb_below_lower = 1'b0;
        steps(2);
        cmp_v(pg_oe, 7'h01);
        sn.fb_above_upper = 1'b1;
        steps(2);
        cmp_v(pg_oe, 7'h00);
        // A low clock enable freezes power-good against a falling output.
        ce = 1'b0;
        sn.fb_below_lower = 1'b1;
        steps(4);
        cmp_v(pg_oe, 7'h00);
        sn.fb_below_lower = 1'b0;
        ce = 1'b1;
        // Trip just after a cycle start, so the cut shows before the next one.
        @(posedge clk_sys);
        if (tick !== 1'b1)
            @(posedge clk_sys);
        @(negedge clk_sys);
        sn.sink_trip = 1'b1;
        steps(1);
        cmp_v(gate, 7'h00);
        sn.sink_trip = 1'b0;
        steps(4);
        cmp_v(gate, 7'h01);
        // Short overload in regulation: count up, then down to the floor.
        @(posedge clk_sys);
        if (tick !== 1'b1)
            @(posedge clk_sys);
        @(negedge clk_sys);
        overload = 1'b1;
        steps(4);
        overload = 1'b0;
        cmp_v(occ, 7'h02);
        steps(2);
        cmp_v(occ, 7'h01);
        steps(6);
        cmp_v(occ, 7'h00);
        cmp_st(state, BCS_RUN);
    endtask
    // Overload in regulation, hiccup, then overload in soft-start.
    task automatic t_overload();
        overload = 1'b1;
        wait_st(BCS_HICCUP, 40);
        sn.hs_demand = 1'b1;
        steps(2);
        cmp_v(gate, 7'h00);
        cmp_v(pg_oe, 7'h01);
        cmp_v(hic, 7'h01);
        overload = 1'b0;
        steps(24);
        cmp_st(state, BCS_HICCUP);
        wait_st(BCS_WAIT_FIRST, 12);
        cmp_v(occ, 7'h00);
        wait_st(BCS_SOFT_START, 4);
        sn.hs_demand = 1'b0;
        overload = 1'b1;
        steps(4);
        sn.hs_demand = 1'b1;
        steps(40);
        cmp_v(gate, 7'h01);
        cmp_st(state, BCS_SOFT_START);
        wait_st(BCS_HICCUP, 9000);
        overload = 1'b0;
    endtask
    // Thermal shutdown, then soft-stop on disable.
    task automatic t_shutdown();
        wait_st(BCS_SOFT_START, 40);
        sn.thermal_shutdown = 1'b1;
        steps(2);
        cmp_v(gate, 7'h00);
        cmp_st(state, BCS_OFF);
        cmp_v(ref_level, 7'h00);
        sn.thermal_shutdown = 1'b0;
        wait_st(BCS_WAIT_FIRST, 10);
        wait_st(BCS_RUN, 5000);
        sn.en_ok = 1'b0;
        wait_st(BCS_SOFT_STOP, 4);
        steps(2);
        cmp_v(gate, 7'h02);
        wait_st(BCS_OFF, 6000);
        cmp_v(ref_level, 7'h00);
        steps(1);
        cmp_v(gate, 7'h00);
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        sn = '0;
        ce = 1'b1;
        nrst = 1'b0;
        overload = 1'b0;
        bad_count = 0;
        checks_done = 0;
        t_reset();
        t_startup();
        t_run_checks();
        t_overload();
        t_shutdown();
        results();
    end
endmodule // bcs_channel_bench

// ### bench/bcs_channel_properties.sv
// Port checker of the buck channel supervisor.
`timescale 1ns/1ps
module bcs_channel_properties
    import bcs_pkg::*;
#(
    parameter logic [12:0] HICCUP_CYCLES = 13'h1f00
)
(
    // Clock and control.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tick,
    // Indications and drives.
    input wire bcs_sense_type sense,
    input wire bcs_gate_type gate,
    input wire logic power_ok_output_o,
    input wire logic power_ok_output_oe,
    // Status.
    input wire bcs_state_type state,
    input wire logic hiccup_active,
    input wire logic [6:0] ref_level,
    input wire logic [2:0] occ_count
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // No forcing fault present, so ordinary sequencing applies.
    logic calm;
    assign calm = ce && !sense.supply_low_lockout && !sense.thermal_shutdown;
    a_lockout_drives: assert property ((ce && sense.supply_low_lockout) |=> gate == '0)
        else $error("Drives on in supply lockout.");
    a_thermal_off: assert property ((ce && sense.thermal_shutdown) |=> gate == '0 && state == BCS_OFF)
        else $error("Thermal shutdown not honoured.");
    a_prebias_off: assert property (state == BCS_WAIT_FIRST |-> gate == '0)
        else $error("Drives on before first pulse.");
    a_hiccup_pg: assert property (hiccup_active |-> power_ok_output_oe)
        else $error("Power good released in hiccup.");
    a_hiccup_drives: assert property (hiccup_active |-> gate == '0)
        else $error("Drives on in hiccup.");
    a_occ_full: assert property ((calm && state == BCS_RUN && occ_count == 3'h7) |=> hiccup_active)
        else $error("Full counter did not start hiccup.");
    // Counter moves one step at a time, apart from a clear, and never wraps below zero.
    a_occ_step: assert property ((occ_count != $past(occ_count) && occ_count != 3'h0) |->
        (occ_count == $past(occ_count) + 3'h1 ||
        ($past(occ_count) != 3'h0 && occ_count == $past(occ_count) - 3'h1)))
        else $error("Counter step wrong.");
    a_pg_rise: assert property ((calm && state == BCS_RUN && occ_count != 3'h7 &&
        sense.fb_above_upper && !sense.fb_below_lower) |=> !power_ok_output_oe)
        else $error("Power good not released.");
    a_pg_fall: assert property ((ce && sense.fb_below_lower) |=> power_ok_output_oe)
        else $error("Power good not pulled low.");
    a_sink_cut: assert property ((calm && state == BCS_RUN &&
        gate.low_side_gate_drive && sense.sink_trip) |=> !gate.low_side_gate_drive)
        else $error("Low side not cut on sink trip.");
    // Switching cycles counted while the hiccup flag stands.
    logic [12:0] hic_ticks;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hic_ticks <= 13'h0000;
        end
        else if (ce)
        begin
            hic_ticks <= hiccup_active ? hic_ticks + {12'h000, tick} : 13'h0000;
        end
    end
    a_hiccup_len: assert property (($fell(hiccup_active) && $past(calm)) |->
        hic_ticks == HICCUP_CYCLES)
        else $error("Hiccup timeout length wrong.");
    // The reference moves at most one step per switching cycle, apart from a clear.
    a_ref_step: assert property ((ref_level != $past(ref_level) && ref_level != 7'h00) |->
        ($past(tick) && (ref_level == $past(ref_level) + 7'h01 ||
        ref_level == $past(ref_level) - 7'h01)))
        else $error("Reference step wrong.");
    c_run_full: cover property (state == BCS_RUN && occ_count == 3'h7);
    c_hiccup: cover property ($rose(hiccup_active));
    c_stop: cover property (state == BCS_SOFT_STOP);
endmodule // bcs_channel_properties
bind bcs_channel bcs_channel_properties #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_props (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tick(tick), .sense(sense), .gate(gate),
    .power_ok_output_o(power_ok_output_o), .power_ok_output_oe(power_ok_output_oe),
    .state(state), .hiccup_active(hiccup_active), .ref_level(ref_level),
    .occ_count(occ_count));

// ### bench/bcs_power_stage.sv
// Behavioural power stage seen from one supervisor channel.
`timescale 1ns/1ps
module bcs_power_stage
    import bcs_pkg::*;
(
    // Drives at the switch gates.
    input wire bcs_gate_type gate,
    // Overload command from the bench.
    input wire logic overload,
    // Source limit comparator.
    output logic src_trip
);
    // Current is only sensed through the low-side switch, so a trip
    // can only show while that switch conducts.
    assign src_trip = overload && gate.low_side_gate_drive;
endmodule // bcs_power_stage

// ### inc/bcs_pkg.sv
// Types shared by the buck channel supervisor modules.
package bcs_pkg;
    // Channel sequencing states.
    typedef enum logic [2:0] {
        BCS_OFF = 3'b000,
        BCS_WAIT_FIRST = 3'b001,
        BCS_SOFT_START = 3'b010,
        BCS_RUN = 3'b011,
        BCS_SOFT_STOP = 3'b100,
        BCS_HICCUP = 3'b101
    } bcs_state_type;
    // Commands to the reference ramp.
    typedef enum logic [1:0] {
        BCS_RAMP_HOLD = 2'b00,
        BCS_RAMP_UP = 2'b01,
        BCS_RAMP_DOWN = 2'b10,
        BCS_RAMP_CLEAR = 2'b11
    } bcs_ramp_cmd_type;
    // Comparator and modulator indications, all synchronous to clk_sys.
    typedef struct packed {
        logic en_ok;
        logic supply_low_lockout;
        logic thermal_shutdown;
        logic hs_demand;
        logic ref_above_fb;
        logic src_trip;
        logic sink_trip;
        logic fb_above_upper;
        logic fb_below_lower;
    } bcs_sense_type;
    // Gate drive pair.
    typedef struct packed {
        logic high_side_gate_drive;
        logic low_side_gate_drive;
    } bcs_gate_type;
    // Ramp state.
    typedef struct packed {
        logic [6:0] level;
        logic [4:0] pre;
        logic [12:0] len;
    } bcs_ramp_st_type;
    // Overcurrent counter state.
    typedef struct packed {
        logic [2:0] cnt;
    } bcs_occ_st_type;
    // Top-level channel state.
    typedef struct packed {
        bcs_state_type st;
        logic [12:0] hic;
        logic src_seen;
        logic skip;
        logic sink_cut;
        logic pg_ok;
        bcs_gate_type gate;
        logic pg_oe;
        logic hiccup;
    } bcs_chan_st_type;
endpackage

// ### inc/bcs_regs.svh
// Constants for the buck channel supervisor: counts in switching cycles.
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH
// Reference code for full regulation voltage, one step being 1/64.
`define BCS_REF_FULL 7'h40
// Last prescaler value: 32 cycles per step, 64 steps give 2048 cycles.
`define BCS_STEP_LAST 5'h1f
// Normal soft-start length in switching cycles.
`define BCS_SS_NORMAL 13'h0800
// Longest adaptive soft-start, twice the normal length.
`define BCS_SS_MAX 13'h1000
// Hiccup timeout in switching cycles (7936).
`define BCS_HICCUP_CYCLES 13'h1f00
// Full value of the 3-bit overcurrent counter.
`define BCS_OCC_FULL 3'h7
`endif

// ### verilog/bcs_channel.sv
// One channel of the step-down regulator fault and sequencing supervisor.
//
// Notes on behaviour
// - After soft-start, count source-limit tripped cycles.
// - Untripped cycle decrements counter, stopping at zero.
// - Counter at seven: drives off, 7936-cycle hiccup.
// - Hiccup end starts a fresh soft-start.
// - Soft-start trips skip; full counter rolls ramp back.
// - Soft-start at double length: off 7936 cycles.
// - Upper threshold releases power-good high.
// - Lower threshold drives power-good low.
// - Power-good held low throughout hiccup.
// - Both drives off until first modulator pulse.
// - First pulse: reference above feedback or timeout.
// - Low-side source trip skips next high-side cycle.
// - Low-side sink trip cuts low side at once.
// - Supply lockout holds both drives low.
// - Thermal shutdown forces off and resets soft-start.
// - Channel starts only while enable comparator high.
// - Reference steps are 1/64 of final.
// - Adaptive soft-start stretches to 4096 cycles.
// - Disable ramps down, then drives turn off.
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_channel
    import bcs_pkg::*;
#(
    // Hiccup timeout in switching cycles; may be shortened in simulation.
    parameter logic [12:0] HICCUP_CYCLES = `BCS_HICCUP_CYCLES
)
(
    // Clock, reset and freeze.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Switching-cycle start pulse.
    input wire logic tick,
    // Comparator and modulator indications.
    input wire bcs_sense_type sense,
    // Gate drives.
    output bcs_gate_type gate,
    // Open-drain power-good pin; output enable high pulls it low.
    output logic power_ok_output_o,
    output logic power_ok_output_oe,
    // Status.
    output bcs_state_type state,
    output logic hiccup_active,
    output logic [6:0] ref_level,
    output logic [2:0] occ_count
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bcs_chan_st_type q_r; // Registered channel state.
    bcs_chan_st_type q_nxt; // Next channel state.
    bcs_ramp_cmd_type ramp_cmd; // Command to the reference ramp.
    logic occ_clear; // Holds the overcurrent counter at zero.
    logic occ_tick; // Counter update strobe.
    logic occ_full; // Counter has reached seven.
    logic cyc_trip; // Source trip seen in the cycle now ending.
    logic locked; // Supply lockout or thermal shutdown.
    logic switching_nxt; // Next state allows switching.
    logic at_top; // Reference at final value.
    logic at_zero; // Reference at zero.
    logic ss_expired; // Normal soft-start time over.
    logic ss_overlong; // Soft-start hit its longest length.

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------

    // Reference ramp for soft-start and soft-stop.
    bcs_ramp u_ramp
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .tick(tick),
        .cmd(ramp_cmd),
        .trip(cyc_trip),
        .rollback(occ_full),
        .level(ref_level),
        .at_top(at_top),
        .at_zero(at_zero),
        .ss_expired(ss_expired),
        .ss_overlong(ss_overlong)
    );

    // Hiccup overcurrent counter.
    bcs_occ u_occ
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .clear(occ_clear),
        .tick(occ_tick),
        .trip(cyc_trip),
        .count(occ_count)
    );

    assign occ_full = (occ_count == `BCS_OCC_FULL);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // All decisions for the channel; inputs are taken as synchronous. Sequencing waits
    // for the cycle tick; lockout, thermal shutdown, a full counter in RUN and power-good act on any clock.
    always_comb
    begin
        q_nxt = q_r;
        locked = sense.supply_low_lockout | sense.thermal_shutdown;
        // A trip in the very cycle the tick clears the latch still counts.
        cyc_trip = q_r.src_seen | (q_r.gate.low_side_gate_drive & sense.src_trip);

        // Source trip is only meaningful during the low-side on-time.
        if (q_r.gate.low_side_gate_drive && sense.src_trip)
        begin
            q_nxt.src_seen = 1'b1;
        end
        // Per-cycle bookkeeping at the start of each switching cycle.
        if (tick)
        begin
            q_nxt.skip = cyc_trip;
            q_nxt.src_seen = 1'b0;
            q_nxt.sink_cut = 1'b0;
        end
        // Sink trip cuts the low side; it follows the clear, so a tick never hides it.
        if (q_r.gate.low_side_gate_drive && sense.sink_trip)
        begin
            q_nxt.sink_cut = 1'b1;
        end


        // Sequencer; transitions happen at the cycle tick.
        if (tick)
        begin
            unique case (q_r.st)
                BCS_OFF:
                begin
                    if (sense.en_ok)
                    begin
                        q_nxt.st = BCS_WAIT_FIRST;
                    end
                end
                BCS_WAIT_FIRST:
                begin
                    if (!sense.en_ok)
                    begin
                        q_nxt.st = BCS_OFF;
                    end
                    else if (sense.ref_above_fb || ss_expired)
                    begin
                        q_nxt.st = BCS_SOFT_START;
                    end
                end
                BCS_SOFT_START:
                begin
                    if (!sense.en_ok)
                    begin
                        q_nxt.st = BCS_SOFT_STOP;
                    end
                    else if (ss_overlong)
                    begin
                        q_nxt.st = BCS_HICCUP;
                        q_nxt.hic = 13'h0000;
                    end
                    else if (at_top)
                    begin
                        q_nxt.st = BCS_RUN;
                    end
                end
                BCS_RUN:
                begin
                    if (!sense.en_ok)
                    begin
                        q_nxt.st = BCS_SOFT_STOP;
                    end
                end
                BCS_SOFT_STOP:
                begin
                    if (sense.en_ok)
                    begin
                        q_nxt.st = BCS_SOFT_START;
                    end
                    else if (at_zero)
                    begin
                        q_nxt.st = BCS_OFF;
                    end
                end
                BCS_HICCUP:
                begin
                    if (q_r.hic == HICCUP_CYCLES - 13'h0001)
                    begin
                        q_nxt.st = BCS_WAIT_FIRST;
                    end
                    else
                    begin
                        q_nxt.hic = q_r.hic + 13'h0001;
                    end
                end
                default:
                begin
                    q_nxt.st = BCS_OFF;
                end
            endcase
        end

        // A full counter after soft-start stops the channel at once; during
        // soft-start the same condition only rolls the ramp back.
        if (q_r.st == BCS_RUN && occ_full)
        begin
            q_nxt.st = BCS_HICCUP;
            q_nxt.hic = 13'h0000;
        end

        // Lockout and thermal shutdown override everything, any cycle.
        if (locked)
        begin
            q_nxt.st = BCS_OFF;
            q_nxt.hic = 13'h0000;
        end

        // Gate drives follow the next state so they change with it.
        switching_nxt = (q_nxt.st == BCS_SOFT_START) || (q_nxt.st == BCS_RUN) ||
                        (q_nxt.st == BCS_SOFT_STOP);
        // High side only on a modulator pulse in an unskipped cycle.
        q_nxt.gate.high_side_gate_drive = switching_nxt & sense.hs_demand &
                                          ~q_nxt.skip;
        // Low side is the complement unless a sink trip cut it.
        q_nxt.gate.low_side_gate_drive = switching_nxt &
                                         ~q_nxt.gate.high_side_gate_drive &
                                         ~q_nxt.sink_cut;

        // Power-good with hysteresis; forced low off, locked or in hiccup.
        if (sense.fb_above_upper)
        begin
            q_nxt.pg_ok = 1'b1;
        end
        if (sense.fb_below_lower)
        begin
            q_nxt.pg_ok = 1'b0;
        end
        if (q_nxt.st == BCS_HICCUP || q_nxt.st == BCS_OFF)
        begin
            q_nxt.pg_ok = 1'b0;
        end
        q_nxt.pg_oe = ~q_nxt.pg_ok;
        q_nxt.hiccup = (q_nxt.st == BCS_HICCUP);
    end

    // Ramp and counter steering from the present state.
    always_comb
    begin
        ramp_cmd = BCS_RAMP_HOLD;
        unique case (q_r.st)
            BCS_OFF, BCS_HICCUP:
            begin
                ramp_cmd = BCS_RAMP_CLEAR;
            end
            BCS_WAIT_FIRST, BCS_SOFT_START:
            begin
                ramp_cmd = BCS_RAMP_UP;
            end
            BCS_SOFT_STOP:
            begin
                ramp_cmd = BCS_RAMP_DOWN;
            end
            default:
            begin
                ramp_cmd = BCS_RAMP_HOLD;
            end
        endcase
        // Thermal shutdown and lockout reset soft-start immediately.
        if (sense.supply_low_lockout || sense.thermal_shutdown)
        begin
            ramp_cmd = BCS_RAMP_CLEAR;
        end
        // A soft-start from OFF or hiccup begins with an empty counter; one from soft-stop keeps it.
        occ_clear = (q_r.st == BCS_OFF) || (q_r.st == BCS_HICCUP) ||
                    (q_r.st == BCS_WAIT_FIRST);
        occ_tick = tick && ((q_r.st == BCS_SOFT_START) || (q_r.st == BCS_RUN) ||
                            (q_r.st == BCS_SOFT_STOP));
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset lands in OFF with both drives low and power-good pulled low.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            q_r <= '{st: BCS_OFF, pg_oe: 1'b1, default: '0};
        end
        else if (ce)
        begin
            q_r <= q_nxt;
        end
    end

    // Outputs come straight from the state register, power_ok_output_o tied low.
    assign gate = q_r.gate;
    assign power_ok_output_o = 1'b0;
    assign power_ok_output_oe = q_r.pg_oe;
    assign state = q_r.st;
    assign hiccup_active = q_r.hiccup;
endmodule // bcs_channel

// ### verilog/bcs_occ.sv
// Three-bit saturating overcurrent event counter.
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_occ
    import bcs_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Control.
    input wire logic clear,
    input wire logic tick,
    input wire logic trip,
    // Count.
    output logic [2:0] count
);
    bcs_occ_st_type q_r; // Registered state.
    bcs_occ_st_type q_nxt; // Next state.

    // Count up on a tripped cycle, down otherwise, saturating at both ends.
    always_comb
    begin
        q_nxt = q_r;
        if (clear)
        begin
            q_nxt.cnt = 3'h0;
        end
        else if (tick && trip)
        begin
            if (q_r.cnt != `BCS_OCC_FULL)
            begin
                q_nxt.cnt = q_r.cnt + 3'h1;
            end
        end
        else if (tick && q_r.cnt != 3'h0)
        begin
            q_nxt.cnt = q_r.cnt - 3'h1;
        end
    end

    // State register; ce low freezes the count.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            q_r <= '0;
        end
        else if (ce)
        begin
            q_r <= q_nxt;
        end
    end

    assign count = q_r.cnt;
endmodule // bcs_occ

// ### verilog/bcs_ramp.sv
// Soft-start and soft-stop reference ramp with adaptive slowing.
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_ramp
    import bcs_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Control.
    input wire logic tick,
    input wire bcs_ramp_cmd_type cmd,
    input wire logic trip,
    input wire logic rollback,
    // Ramp state.
    output logic [6:0] level,
    output logic at_top,
    output logic at_zero,
    output logic ss_expired,
    output logic ss_overlong
);
    bcs_ramp_st_type q_r; // Registered state.
    bcs_ramp_st_type q_nxt; // Next state.

    // A tripped cycle does not advance the prescaler, which slows the rise.
    always_comb
    begin
        q_nxt = q_r;
        if (cmd == BCS_RAMP_CLEAR)
        begin
            q_nxt = '0;
        end
        else if (tick && cmd == BCS_RAMP_UP)
        begin
            if (q_r.len != `BCS_SS_MAX)
            begin
                q_nxt.len = q_r.len + 13'h0001;
            end
            if (rollback && q_r.level != 7'h00)
            begin
                q_nxt.level = q_r.level - 7'h01;
                q_nxt.pre = 5'h00;
            end
            else if (!trip)
            begin
                q_nxt.pre = q_r.pre + 5'h01;
                if (q_r.pre == `BCS_STEP_LAST && q_r.level != `BCS_REF_FULL)
                begin
                    q_nxt.level = q_r.level + 7'h01;
                end
            end
        end
        else if (tick && cmd == BCS_RAMP_DOWN)
        begin
            q_nxt.pre = q_r.pre + 5'h01;
            if (q_r.pre == `BCS_STEP_LAST && q_r.level != 7'h00)
            begin
                q_nxt.level = q_r.level - 7'h01;
            end
        end
    end

    // State register; ce low freezes the ramp.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            q_r <= '0;
        end
        else if (ce)
        begin
            q_r <= q_nxt;
        end
    end

    assign level = q_r.level;
    assign at_top = (q_r.level == `BCS_REF_FULL);
    assign at_zero = (q_r.level == 7'h00);
    assign ss_expired = (q_r.len >= `BCS_SS_NORMAL);
    assign ss_overlong = (q_r.len >= `BCS_SS_MAX);
endmodule // bcs_ramp
